// ==== pci_flash_pkg.sv ====
// Shared constants and types for the PCI to flash array bridge and its bus master
package pci_flash_pkg;
   // ---------------------------------------------------------------
   // PCI bus commands
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
   localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
   localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
   // ---------------------------------------------------------------
   // Transaction timing, in bus clocks counted from the address clock; master abort counted from the first data clock
   // ---------------------------------------------------------------
   localparam logic [3:0] DEVSEL_CLK = 4'h4;
   localparam logic [3:0] RD_DATA_CLK = 4'hA;
   localparam logic [3:0] WR_DONE_CLK = 4'h5;
   localparam logic [3:0] ROM_DATA_CLK = 4'hC;
   localparam logic [3:0] ROM_HALF_CLK = 4'h7;
   localparam logic [3:0] MASTER_ABORT_CLK = 4'h6;
   // ---------------------------------------------------------------
   // Configuration header dword indices, fields and reset values
   // ---------------------------------------------------------------
   localparam logic [5:0] CFG_ID_IDX = 6'h00;
   localparam logic [5:0] CFG_CMD_IDX = 6'h01;
   localparam logic [5:0] CFG_CLASS_IDX = 6'h02;
   localparam logic [5:0] CFG_BAR0_IDX = 6'h04;
   localparam logic [5:0] CFG_ROM_IDX = 6'h0C;
   localparam logic [5:0] CFG_INT_IDX = 6'h0F;
   localparam int MEM_EN_BIT = 1;
   localparam int ROM_EN_BIT = 0;
   localparam int BAR0_LSB = 25;
   localparam int ROM_BAR_LSB = 18;
   localparam logic [15:0] STATUS_RESET = 16'h0400;
   localparam logic [23:0] CLASS_CODE = 24'h050100;
   localparam logic [6:0] BAR0_RESET = 7'h00;
   localparam logic [13:0] ROM_BAR_RESET = 14'h0000;
   localparam logic [7:0] INT_LINE_RESET = 8'hFF;
   // ---------------------------------------------------------------
   // Array geometry
   // ---------------------------------------------------------------
   localparam int NUM_BANKS = 4;
   localparam int NUM_LANES = 4;
   localparam int DEV_ADDR_W = 21;
   localparam int ROM_ADDR_W = 17;
   typedef enum logic [1:0] {
      SIZE_2MB = 2'h0,
      SIZE_8MB = 2'h1,
      SIZE_16MB = 2'h2,
      SIZE_32MB = 2'h3
   } size_mode_e;
   // ---------------------------------------------------------------
   // Flash command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] FC_READ_ARRAY = 8'hFF;
   localparam logic [7:0] FC_READ_ID = 8'h90;
   localparam logic [7:0] FC_READ_STATUS = 8'h70;
   localparam logic [7:0] FC_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] FC_ERASE = 8'h20;
   localparam logic [7:0] FC_PROGRAM = 8'h40;
   localparam logic [7:0] FC_PROGRAM_ALT = 8'h10;
   localparam logic [7:0] FC_SUSPEND = 8'hB0;
   localparam logic [7:0] FC_RESUME = 8'hD0;
   localparam logic [7:0] FC_LOCK_SETUP = 8'h60;
   // Master outcome codes
   localparam logic [1:0] RES_OK = 2'h0;
   localparam logic [1:0] RES_ABORT = 2'h1;
   localparam logic [1:0] RES_RETRY = 2'h2;
   localparam logic [1:0] RES_REFUSED = 2'h3;
endpackage

// ==== pci_flash_link.sv ====
// PCI bus wires between the bus master end and the flash bridge target end
`timescale 1ns/1ps
interface pci_flash_link;
   // Master driven lines
   logic frame_n;
   logic irdy_n;
   logic idsel;
   logic [3:0] cbe_n;
   logic [31:0] m_ad_o;
   logic m_ad_oe;
   // Target driven lines
   logic [31:0] t_ad_o;
   logic t_ad_oe;
   logic t_devsel_n_o;
   logic t_trdy_n_o;
   logic t_stop_n_o;
   logic t_ctl_oe;
   // Resolved bus, undriven lines float high through pull-ups
   logic [31:0] ad;
   logic devsel_n;
   logic trdy_n;
   logic stop_n;
   assign ad = t_ad_oe ? t_ad_o : (m_ad_oe ? m_ad_o : 32'hFFFFFFFF);
   assign devsel_n = t_ctl_oe ? t_devsel_n_o : 1'b1;
   assign trdy_n = t_ctl_oe ? t_trdy_n_o : 1'b1;
   assign stop_n = t_ctl_oe ? t_stop_n_o : 1'b1;
   modport target(input frame_n, irdy_n, idsel, cbe_n, ad,
      output t_ad_o, t_ad_oe, t_devsel_n_o, t_trdy_n_o, t_stop_n_o, t_ctl_oe);
   modport master(output frame_n, irdy_n, idsel, cbe_n, m_ad_o, m_ad_oe,
      input ad, devsel_n, trdy_n, stop_n);
endinterface

// ==== pci_flash_lane_decode.sv ====
// Bank and byte lane chip select decode for the banked flash array
`timescale 1ns/1ps
module pci_flash_lane_decode
   import pci_flash_pkg::*;
#(
   parameter int BANKS = NUM_BANKS,
   parameter int LANES = NUM_LANES
) (
   // Access
   input wire logic [24:0] i_addr,
   input wire logic [3:0] i_be_n,
   input wire size_mode_e i_size,
   // Decoded selects
   output logic [BANKS*LANES-1:0] o_sel_n,
   output logic [DEV_ADDR_W-1:0] o_dev_addr
);
   logic [1:0] bank;
   logic bank_ok;

   if (BANKS != 4 || LANES != 4) begin : g_check
      $error("Decode serves exactly four banks of four lanes");
   end

   // Bank field and in-device address follow the array size
   always_comb begin
      bank = i_addr[24:23];
      bank_ok = 1'b1;
      o_dev_addr = i_addr[22:2];
      unique case (i_size)
         SIZE_2MB: begin
            bank = i_addr[22:21];
            bank_ok = (bank == 2'h0);
            o_dev_addr = {2'h0, i_addr[20:2]};
         end
         SIZE_8MB: bank_ok = (bank == 2'h0);
         SIZE_16MB: bank_ok = !bank[1];
         SIZE_32MB: bank_ok = 1'b1;
      endcase
   end

   // One select per device, only inside the decoded bank and enabled lanes
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      for (genvar l = 0; l < LANES; l++) begin : g_lane
         assign o_sel_n[b*LANES+l] = !(bank_ok && bank == 2'(b) && !i_be_n[l]);
      end
   end
endmodule // pci_flash_lane_decode

// ==== pci_flash_bridge.sv ====
// PCI target bridge that steers single data phase cycles onto a banked flash array
// Summary of operation
// - Answer PCI target cycles, 32-bit 33 MHz bus
// - Drive flash address, data, strobes per command
// - Four banks of four devices, own selects
// - Array size 2, 8, 16 or 32 megabytes
// - Byte lanes 0-3 map to selects 4b to 4b+3 of bank b
// - One data phase, then disconnect
// - Host sequences program and erase itself
// - Expansion ROM read sixteen bits at a time
// - Bridge holds ID, command, class, BAR0, ROM and interrupt line header dwords, others read zero
// - Host selects read modes FF, 90, 70
// - Host clears status 50, suspends B0, resumes D0
// - Host starts erase 20, program 40/10
// - Host lock operations start with 60
// - Host writes only listed command codes
// - Read: devsel clock 4, data clock 10, expansion ROM data clock 12
// - Write: devsel slow, done clock 5, stop
// - Host word writes stay inside one dword
`timescale 1ns/1ps
module pci_flash_bridge
   import pci_flash_pkg::*;
#(
   parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h5678, // Arbitrary value
   parameter logic [7:0] REVISION_ID = 8'h01 // Arbitrary value
) (
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   // Array size strap
   input wire logic [1:0] i_size_mode,
   // PCI bus
   pci_flash_link.target pci,
   // Flash array
   output logic [DEV_ADDR_W-1:0] o_flash_addr,
   output logic [NUM_BANKS*NUM_LANES-1:0] o_flash_sel_n,
   output logic o_flash_oe_n,
   output logic o_flash_we_n,
   output logic [31:0] o_flash_data,
   output logic o_flash_data_oe,
   input wire logic [31:0] i_flash_data,
   output logic o_flash_powerdown_reset_n,
   // Expansion ROM
   output logic [ROM_ADDR_W-1:0] o_rom_addr,
   output logic o_rom_sel_n,
   output logic o_rom_oe_n,
   input wire logic [15:0] i_rom_data
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DATA = 2'b11,
      ST_TURN = 2'b10
   } state_e;
   typedef enum logic [1:0] {
      K_FLASH = 2'h0,
      K_ROM = 2'h1,
      K_CFG = 2'h2
   } kind_e;

   state_e state_r;
   kind_e kind_r;
   logic write_r;
   logic [31:0] addr_r;
   logic [3:0] be_n_r;
   logic [3:0] cnt_r;
   logic seen_r;
   logic [31:0] wdata_r;
   logic [31:0] rdata_r;
   logic devsel_n_r, trdy_n_r, stop_n_r, ctl_oe_r, ad_oe_r;
   logic [5:0] size_sync_r;
   size_mode_e size_r;
   logic mem_en_r, rom_en_r;
   logic [6:0] bar0_r;
   logic [13:0] rombar_r;
   logic [7:0] int_line_r;
   logic [3:0] cmd_a;
   logic mem_rd_a, mem_wr_a, cfg_hit, flash_hit, rom_hit;
   logic [3:0] done_clk;
   logic ready_now, xfer;
   logic [NUM_BANKS*NUM_LANES-1:0] sel_n_dec;
   logic [DEV_ADDR_W-1:0] dev_addr_dec;
   logic [31:0] cfg_rdata;

   // ---------------------------------------------------------------
   // Address phase decode
   // ---------------------------------------------------------------
   assign cmd_a = pci.cbe_n;
   assign mem_rd_a = cmd_a == CMD_MEM_RD || cmd_a == CMD_MEM_RD_MULT || cmd_a == CMD_MEM_RD_LINE;
   assign mem_wr_a = cmd_a == CMD_MEM_WR || cmd_a == CMD_MEM_WR_INV;
   assign cfg_hit = pci.idsel && (cmd_a == CMD_CFG_RD || cmd_a == CMD_CFG_WR)
      && pci.ad[1:0] == 2'h0;
   assign flash_hit = mem_en_r && (mem_rd_a || mem_wr_a)
      && pci.ad[31:BAR0_LSB] == bar0_r;
   assign rom_hit = mem_en_r && rom_en_r && mem_rd_a
      && pci.ad[31:ROM_BAR_LSB] == rombar_r;

   // Clock on which TRDY and STOP go low for this kind of cycle
   always_comb begin
      done_clk = RD_DATA_CLK;
      if (write_r) begin
         done_clk = WR_DONE_CLK;
      end else if (kind_r == K_ROM) begin
         done_clk = ROM_DATA_CLK;
      end
   end
   assign ready_now = state_r == ST_DATA && cnt_r >= done_clk - 4'h1 && seen_r;
   assign xfer = state_r == ST_DATA && !trdy_n_r && !pci.irdy_n;

   // ---------------------------------------------------------------
   // Array size strap, three stage synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         size_sync_r <= 6'h00;
         size_r <= SIZE_2MB;
      end else if (i_clk_en) begin
         size_sync_r <= {size_sync_r[3:0], i_size_mode};
         if (size_sync_r[3:2] == size_sync_r[5:4]) size_r <= size_mode_e'(size_sync_r[5:4]);
      end
   end

   // ---------------------------------------------------------------
   // Transaction sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= ST_IDLE;
         kind_r <= K_FLASH;
         write_r <= 1'b0;
         addr_r <= 32'h0;
         cnt_r <= 4'h0;
         seen_r <= 1'b0;
         be_n_r <= 4'hF;
         wdata_r <= 32'h0;
      end else if (i_clk_en) begin
         unique case (state_r)
            ST_IDLE: begin
               seen_r <= 1'b0;
               cnt_r <= 4'h2; // The clock after the address clock is clock 2
               if (!pci.frame_n && (cfg_hit || flash_hit || rom_hit)) begin
                  state_r <= ST_WAIT;
                  addr_r <= pci.ad;
                  write_r <= cfg_hit ? cmd_a[0] : mem_wr_a;
                  kind_r <= cfg_hit ? K_CFG : (rom_hit ? K_ROM : K_FLASH);
               end
            end
            ST_WAIT, ST_DATA: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == DEVSEL_CLK - 4'h1) begin
                  state_r <= ST_DATA;
               end
               // Lanes and write data taken once the master is ready
               if (!pci.irdy_n && !seen_r) begin
                  seen_r <= 1'b1;
                  be_n_r <= pci.cbe_n;
                  wdata_r <= pci.ad;
               end
               if (xfer) begin
                  state_r <= ST_TURN;
               end
            end
            ST_TURN: state_r <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Target control lines: slow devsel, data clock with stop
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         devsel_n_r <= 1'b1;
         trdy_n_r <= 1'b1;
         stop_n_r <= 1'b1;
         ctl_oe_r <= 1'b0;
      end else if (i_clk_en) begin
         if (state_r != ST_IDLE && cnt_r == DEVSEL_CLK - 4'h1 && !xfer) begin
            devsel_n_r <= 1'b0;
            ctl_oe_r <= 1'b1;
         end
         if (ready_now && trdy_n_r && !xfer) begin
            trdy_n_r <= 1'b0;
            stop_n_r <= 1'b0;
         end
         if (xfer) begin
            devsel_n_r <= 1'b1;
            trdy_n_r <= 1'b1;
            stop_n_r <= 1'b1;
         end
         if (state_r == ST_TURN) begin
            ctl_oe_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read data capture and AD drive
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_r <= 32'h0;
         ad_oe_r <= 1'b0;
      end else if (i_clk_en) begin
         if (state_r == ST_DATA && !write_r && kind_r == K_ROM
               && cnt_r == ROM_HALF_CLK - 4'h1) begin
            rdata_r[15:0] <= i_rom_data;
         end
         if (ready_now && trdy_n_r && !write_r && !xfer) begin
            ad_oe_r <= 1'b1;
            unique case (kind_r)
               K_FLASH: rdata_r <= i_flash_data;
               K_ROM: rdata_r[31:16] <= i_rom_data;
               K_CFG: rdata_r <= cfg_rdata;
               default: rdata_r <= 32'hFFFFFFFF;
            endcase
         end
         if (xfer) begin
            ad_oe_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration header
   // ---------------------------------------------------------------
   always_comb begin
      unique case (addr_r[7:2])
         CFG_ID_IDX: cfg_rdata = {DEVICE_ID, VENDOR_ID};
         CFG_CMD_IDX: cfg_rdata = {STATUS_RESET, 14'h0, mem_en_r, 1'b0};
         CFG_CLASS_IDX: cfg_rdata = {CLASS_CODE, REVISION_ID};
         CFG_BAR0_IDX: cfg_rdata = {bar0_r, 25'h0};
         CFG_ROM_IDX: cfg_rdata = {rombar_r, 17'h0, rom_en_r};
         CFG_INT_IDX: cfg_rdata = {24'h0, int_line_r};
         default: cfg_rdata = 32'h0;
      endcase
   end

   // Configuration writes land on the transfer clock, per byte lane
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         mem_en_r <= 1'b0;
         rom_en_r <= 1'b0;
         bar0_r <= BAR0_RESET;
         rombar_r <= ROM_BAR_RESET;
         int_line_r <= INT_LINE_RESET;
      end else if (i_clk_en && xfer && write_r && kind_r == K_CFG) begin
         unique case (addr_r[7:2])
            CFG_CMD_IDX: if (!be_n_r[0]) mem_en_r <= wdata_r[MEM_EN_BIT];
            CFG_BAR0_IDX: if (!be_n_r[3]) bar0_r <= wdata_r[31:BAR0_LSB];
            CFG_ROM_IDX: begin
               if (!be_n_r[0]) rom_en_r <= wdata_r[ROM_EN_BIT];
               if (!be_n_r[3]) rombar_r[13:6] <= wdata_r[31:24];
               if (!be_n_r[2]) rombar_r[5:0] <= wdata_r[23:18];
            end
            CFG_INT_IDX: if (!be_n_r[0]) int_line_r <= wdata_r[7:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Flash and ROM strobes
   // ---------------------------------------------------------------
   pci_flash_lane_decode u_decode (
      .i_addr(addr_r[24:0]),
      .i_be_n(be_n_r),
      .i_size(size_r),
      .o_sel_n(sel_n_dec),
      .o_dev_addr(dev_addr_dec)
   );

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_flash_addr <= '0;
         o_flash_sel_n <= '1;
         o_flash_oe_n <= 1'b1;
         o_flash_we_n <= 1'b1;
         o_flash_data <= 32'h0;
         o_flash_data_oe <= 1'b0;
         o_flash_powerdown_reset_n <= 1'b0;
         o_rom_addr <= '0;
         o_rom_sel_n <= 1'b1;
         o_rom_oe_n <= 1'b1;
      end else if (i_clk_en) begin
         o_flash_powerdown_reset_n <= 1'b1;
         o_flash_addr <= dev_addr_dec;
         o_flash_data <= wdata_r;
         o_rom_addr <= {addr_r[ROM_BAR_LSB-1:2], cnt_r >= ROM_HALF_CLK - 4'h1};
         if (state_r inside {ST_WAIT, ST_DATA} && seen_r && !xfer && kind_r == K_FLASH) begin
            o_flash_sel_n <= sel_n_dec;
            o_flash_oe_n <= write_r;
            o_flash_data_oe <= write_r;
            o_flash_we_n <= !write_r || !trdy_n_r || ready_now;
         end else begin
            o_flash_sel_n <= '1;
            o_flash_oe_n <= 1'b1;
            o_flash_we_n <= 1'b1;
            o_flash_data_oe <= state_r == ST_TURN && o_flash_data_oe;
         end
         o_rom_sel_n <= !(state_r == ST_DATA && kind_r == K_ROM && !xfer);
         o_rom_oe_n <= !(state_r == ST_DATA && kind_r == K_ROM && !xfer);
      end
   end

   // ---------------------------------------------------------------
   // Bus drive
   // ---------------------------------------------------------------
   assign pci.t_ad_o = rdata_r;
   assign pci.t_ad_oe = ad_oe_r;
   assign pci.t_devsel_n_o = devsel_n_r;
   assign pci.t_trdy_n_o = trdy_n_r;
   assign pci.t_stop_n_o = stop_n_r;
   assign pci.t_ctl_oe = ctl_oe_r;
endmodule // pci_flash_bridge

// ==== pci_flash_master.sv ====
// PCI bus master that issues single data phase cycles to the flash bridge
`timescale 1ns/1ps
module pci_flash_master
   import pci_flash_pkg::*;
(
   // Clock, reset, enable
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   // User request
   input wire logic i_req,
   input wire logic i_write,
   input wire logic i_cfg,
   input wire logic i_cmd,
   input wire logic [31:0] i_addr,
   input wire logic [3:0] i_be_n,
   input wire logic [31:0] i_wdata,
   output logic o_ready,
   // User answer
   output logic o_done,
   output logic [1:0] o_result,
   output logic [31:0] o_rdata,
   // PCI bus
   pci_flash_link.master pci
);
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_ADDR = 2'b01,
      M_DATA = 2'b11,
      M_TURN = 2'b10
   } mstate_e;

   mstate_e state_r;
   logic write_r, cfg_r;
   logic [31:0] addr_r, wdata_r;
   logic [3:0] be_n_r;
   logic [3:0] cnt_r;
   logic refuse;

   // Only listed command codes may be written as commands
   function automatic logic listed(input logic [7:0] code);
      listed = code == FC_READ_ARRAY || code == FC_READ_ID || code == FC_READ_STATUS
         || code == FC_CLEAR_STATUS || code == FC_ERASE || code == FC_PROGRAM
         || code == FC_PROGRAM_ALT || code == FC_SUSPEND || code == FC_RESUME
         || code == FC_LOCK_SETUP;
   endfunction

   // Refuse unaligned memory cycles and unlisted command bytes
   always_comb begin
      refuse = !i_cfg && i_addr[1:0] != 2'h0;
      for (int l = 0; l < 4; l++) begin
         if (i_write && i_cmd && !i_be_n[l] && !listed(i_wdata[8*l +: 8])) begin
            refuse = 1'b1;
         end
      end
   end

   assign o_ready = state_r == M_IDLE && i_clk_en;

   // Cycle sequencer, one data phase per request
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= M_IDLE;
         write_r <= 1'b0;
         cfg_r <= 1'b0;
         addr_r <= 32'h0;
         wdata_r <= 32'h0;
         be_n_r <= 4'hF;
         cnt_r <= 4'h0;
         o_done <= 1'b0;
         o_result <= RES_OK;
         o_rdata <= 32'h0;
      end else if (i_clk_en) begin
         o_done <= 1'b0;
         unique case (state_r)
            M_IDLE: begin
               cnt_r <= 4'h1;
               if (i_req && refuse) begin
                  o_done <= 1'b1;
                  o_result <= RES_REFUSED;
               end else if (i_req) begin
                  state_r <= M_ADDR;
                  write_r <= i_write;
                  cfg_r <= i_cfg;
                  addr_r <= i_addr;
                  wdata_r <= i_wdata;
                  be_n_r <= i_be_n;
               end
            end
            M_ADDR: state_r <= M_DATA;
            M_DATA: begin
               cnt_r <= cnt_r + 4'h1;
               if (!pci.trdy_n) begin
                  state_r <= M_TURN;
                  o_done <= 1'b1;
                  o_result <= RES_OK;
                  if (!write_r) o_rdata <= pci.ad;
               end else if (!pci.stop_n) begin
                  state_r <= M_TURN;
                  o_done <= 1'b1;
                  o_result <= RES_RETRY;
               end else if (pci.devsel_n && cnt_r >= MASTER_ABORT_CLK) begin
                  state_r <= M_TURN;
                  o_done <= 1'b1;
                  o_result <= RES_ABORT;
                  o_rdata <= 32'hFFFFFFFF;
               end
            end
            M_TURN: state_r <= M_IDLE;
         endcase
      end
   end

   // Bus drive; frame rises with irdy low so the cycle has one data phase
   assign pci.frame_n = state_r != M_ADDR;
   assign pci.irdy_n = state_r != M_DATA;
   assign pci.idsel = state_r == M_ADDR && cfg_r;
   assign pci.cbe_n = state_r == M_ADDR
      ? (cfg_r ? {CMD_CFG_RD[3:1], write_r} : {CMD_MEM_RD[3:1], write_r})
      : be_n_r;
   assign pci.m_ad_o = state_r == M_ADDR ? addr_r : wdata_r;
   assign pci.m_ad_oe = state_r == M_ADDR || (state_r == M_DATA && write_r);
endmodule // pci_flash_master

// ==== pci_flash_monitor.sv ====
// Protocol checker for the PCI link between bus master and flash bridge
`timescale 1ns/1ps
module pci_flash_monitor
   import pci_flash_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Bus lines
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic [3:0] cbe_n,
   input wire logic [31:0] ad,
   input wire logic devsel_n,
   input wire logic trdy_n,
   input wire logic stop_n
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // Target answer timing counted from the address clock
   property p_dev; $fell(frame_n) |-> ##1 devsel_n [*2] ##1 !devsel_n; endproperty
   property p_rd;
      $fell(frame_n) && cbe_n == CMD_MEM_RD && !ad[25] |-> ##1 trdy_n [*8] ##1 !trdy_n;
   endproperty
   // Expansion ROM window sits at 32 MB in this bench and answers on clock 12
   property p_rom;
      $fell(frame_n) && cbe_n == CMD_MEM_RD && ad[25]
         |-> ##1 trdy_n [*8] ##1 trdy_n [*2] ##1 !trdy_n;
   endproperty
   property p_wr; $fell(frame_n) && cbe_n == CMD_MEM_WR |-> ##1 trdy_n [*3] ##1 !trdy_n; endproperty
   // One data phase, then disconnect and let go
   property p_stop; !trdy_n |-> !stop_n && !devsel_n; endproperty
   property p_rel; !trdy_n && !irdy_n |=> trdy_n && stop_n && devsel_n; endproperty
   property p_hold; !devsel_n && trdy_n |=> !devsel_n; endproperty
   property p_sd; !stop_n |-> !trdy_n; endproperty
   property p_last; !trdy_n |-> frame_n && !irdy_n; endproperty
   a_dev: assert property (p_dev) else $error("devsel not on clock 4");
   a_rd: assert property (p_rd) else $error("read data not on clock 10");
   a_rom: assert property (p_rom) else $error("rom data not on clock 12");
   a_wr: assert property (p_wr) else $error("write not done on clock 5");
   a_stop: assert property (p_stop) else $error("trdy without stop");
   a_rel: assert property (p_rel) else $error("target held past data phase");
   a_hold: assert property (p_hold) else $error("devsel dropped early");
   a_sd: assert property (p_sd) else $error("stop without data");
   a_last: assert property (p_last) else $error("data phase not last");
   // Main traffic kinds
   c_rd: cover property ($fell(frame_n) && cbe_n == CMD_MEM_RD);
   c_wr: cover property ($fell(frame_n) && cbe_n == CMD_MEM_WR);
   c_end: cover property (!trdy_n && !irdy_n);
endmodule // pci_flash_monitor

// ==== tb_pci_to_flash_array_bridge.sv ====
// Testbench joining bus master and flash bridge across the PCI link
`timescale 1ns/1ps
module tb_pci_to_flash_array_bridge;
   import pci_flash_pkg::*;
   logic i_clock = 1'h0;
   logic i_nrst = 1'h0;
   logic req = 1'h0, wr = 1'h0, cfg = 1'h0, cmd = 1'h0, rdy, done;
   logic [31:0] addr = 32'h0, wd = 32'h0, fdata = 32'h0, od, dat_s, rd;
   logic [3:0] be_n = 4'hF;
   logic [1:0] res;
   logic [20:0] fa, adr_s;
   logic [15:0] sel, sel_s;
   logic [16:0] ra;
   logic [1:0] size_mode = 2'h0;
   logic en = 1'h1, we_n, we_n_s;
   wire logic [15:0] romd = ra[0] ? 16'hBEEF : 16'hCAFE;
   int failures = 0, checked = 0;
   pci_flash_link link ();
   pci_flash_bridge #(.VENDOR_ID(16'hA5A5), .DEVICE_ID(16'h3C3C)) i_pci_flash_bridge (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(en), .i_size_mode(size_mode), .pci(link),
      .o_flash_addr(fa), .o_flash_sel_n(sel), .o_flash_oe_n(), .o_flash_we_n(we_n),
      .o_flash_data(od), .o_flash_data_oe(), .i_flash_data(fdata),
      .o_flash_powerdown_reset_n(), .o_rom_addr(ra), .o_rom_sel_n(), .o_rom_oe_n(),
      .i_rom_data(romd));
   pci_flash_master i_pci_flash_master (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(en),
      .i_req(req), .i_write(wr), .i_cfg(cfg), .i_cmd(cmd), .i_addr(addr), .i_be_n(be_n),
      .i_wdata(wd), .o_ready(rdy), .o_done(done), .o_result(res), .o_rdata(rd), .pci(link));
   pci_flash_monitor i_pci_flash_monitor (.i_clock(i_clock), .i_nrst(i_nrst),
      .frame_n(link.frame_n), .irdy_n(link.irdy_n), .cbe_n(link.cbe_n), .ad(link.ad),
      .devsel_n(link.devsel_n), .trdy_n(link.trdy_n), .stop_n(link.stop_n));
   // Clock at 8 ns
   initial forever #4 i_clock = ~i_clock;
   // Latch the array pins while any device is selected
   always @(posedge i_clock)
      if (sel !== 16'hFFFF) {sel_s, adr_s, dat_s, we_n_s} <= {sel, fa, od, we_n_s & we_n};
   task automatic chk(input string s, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s exp %h seen %h", s, e, g);
      end
   endtask
   // One user request, waits for the master to be idle and for its answer
   task automatic xfer(input logic w, c, k, input logic [31:0] a, d, input logic [3:0] b);
      int n;
      @(negedge i_clock);
      for (n = 0; n < 20 && rdy !== 1'h1; n++) @(negedge i_clock);
      {wr, cfg, cmd, addr, wd, be_n, req} = {w, c, k, a, d, b, 1'h1};
      {sel_s, we_n_s} = {16'hFFFF, 1'h1};
      @(negedge i_clock);
      req = 1'h0;
      for (n = 0; n < 40 && done !== 1'h1; n++) @(negedge i_clock);
      if (done !== 1'h1) failures++;
   endtask
   task automatic t_cfg;
      xfer(1'h1, 1'h1, 1'h0, 32'h4, 32'h2, 4'h0);
      xfer(1'h0, 1'h1, 1'h0, 32'h0, 32'h0, 4'h0);
      chk("cfg id", 32'h3C3CA5A5, rd);
      xfer(1'h1, 1'h1, 1'h0, 32'h30, 32'h2000001, 4'h0);
      xfer(1'h0, 1'h0, 1'h0, 32'h2000000, 32'h0, 4'h0);
      chk("rom data", 32'hBEEFCAFE, rd);
   endtask
   task automatic t_lanes;
      xfer(1'h1, 1'h0, 1'h0, 32'h104, 32'hC3A55A3C, 4'hA);
      chk("wr sel", 16'hFFFA, sel_s);
      chk("wr addr", 21'h41, adr_s);
      chk("wr lanes", 16'hA53C, {dat_s[23:16], dat_s[7:0]});
      chk("wr strobe", 1'h0, we_n_s);
      fdata = 32'h11223344;
      xfer(1'h0, 1'h0, 1'h0, 32'h8, 32'h0, 4'h0);
      chk("rd data", 32'h11223344, rd);
      chk("rd sel", 16'hFFF0, sel_s);
      chk("rd strobe", 1'h1, we_n_s);
      xfer(1'h1, 1'h0, 1'h0, 32'h200000, 32'h0, 4'h0);
      chk("bank sel", 16'hFFFF, sel_s);
      size_mode = 2'h3;
      xfer(1'h1, 1'h0, 1'h0, 32'h1800004, 32'h0, 4'h0);
      chk("32MB sel", 16'h0FFF, sel_s);
      chk("32MB addr", 21'h1, adr_s);
      size_mode = 2'h0;
   endtask
   task automatic t_cmds;
      logic [7:0] c [10] = '{8'hFF, 8'h90, 8'h70, 8'h50, 8'h20, 8'h40, 8'h10, 8'hB0, 8'hD0, 8'h60};
      foreach (c[i]) begin
         xfer(1'h1, 1'h0, 1'h1, 32'h10, {4{c[i]}}, 4'h0);
         chk("cmd res", RES_OK, res);
         chk("cmd data", {4{c[i]}}, dat_s);
      end
   endtask
   task automatic t_refuse;
      xfer(1'h1, 1'h0, 1'h1, 32'h10, 32'h77777777, 4'h0);
      chk("bad code", RES_REFUSED, res);
      xfer(1'h1, 1'h0, 1'h0, 32'h12, 32'h0, 4'h0);
      chk("misaligned", RES_REFUSED, res);
   endtask
   task automatic final_report;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge i_clock);
      @(negedge i_clock) i_nrst = 1'h1;
      t_cfg();
      t_lanes();
      t_cmds();
      t_refuse();
      final_report();
   end
   // Watchdog
   initial begin
      #50us;
      failures++;
      final_report();
   end
endmodule // tb_pci_to_flash_array_bridge
